// ===== hdl/rdip_auto_insert.sv
// control registers and automatic insertion of the path remote defect code
`timescale 1ns/100ps
module rdip_auto_insert (
    input  wire logic        clk_in,      // 10 MHz clock
    input  wire logic        rstn_in,     // synchronous reset, active low
    input  wire logic [15:0] addr_in,     // host register address
    input  wire logic [7:0]  wdata_in,    // host write data
    input  wire logic        wr_in,       // host write strobe, one cycle
    input  wire logic        rd_in,       // host read strobe
    output logic      [7:0]  rdata_out,   // host read data, registered
    input  wire logic        ais_in,      // alarm signal defect declared
    input  wire logic        lop_in,      // pointer loss declared
    input  wire logic        uneq_in,     // unequipped declared
    input  wire logic        tim_in,      // trace mismatch declared
    input  wire logic        plm_in,      // label mismatch declared
    input  wire logic        lcd_in,      // cell delineation loss declared
    input  wire logic [7:0]  g1_in,       // outbound overhead byte from upstream
    output logic      [7:0]  g1_out,      // outbound overhead byte with code, registered
    output logic             rdi_act_out  // an automatic code is being sent, registered
);
    ////////////////////////////////////////////////////////////////////////
    // control registers
    logic [7:0] ctrl0_ff; // pointer loss / alarm signal
    logic [7:0] ctrl1_ff; // trace mismatch / unequipped
    logic [7:0] ctrl2_ff; // delineation loss / label mismatch

    // host writes to the three control bytes
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            ctrl0_ff <= rdip_pkg::CTRL_RESET;
            ctrl1_ff <= rdip_pkg::CTRL_RESET;
            ctrl2_ff <= rdip_pkg::CTRL_RESET;
        end else if (wr_in) begin
            case (addr_in)
                rdip_pkg::ADDR_CTRL_0: ctrl0_ff <= wdata_in;
                rdip_pkg::ADDR_CTRL_1: ctrl1_ff <= wdata_in;
                rdip_pkg::ADDR_CTRL_2: ctrl2_ff <= wdata_in;
                default: ;                                   // unmapped ignored
            endcase
        end
    end

    // readback, unmapped reads as zero
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            rdata_out <= 8'h00;
        end else if (rd_in) begin
            case (addr_in)
                rdip_pkg::ADDR_CTRL_0: rdata_out <= ctrl0_ff;
                rdip_pkg::ADDR_CTRL_1: rdata_out <= ctrl1_ff;
                rdip_pkg::ADDR_CTRL_2: rdata_out <= ctrl2_ff;
                default:               rdata_out <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // field extraction, index order is the priority order
    logic [5:0]  enables; // per defect enable bits
    logic [5:0]  declared; // per defect declarations
    logic [17:0] codes;   // per defect code fields
    logic [5:0]  active;  // declared and enabled
    logic [2:0]  sel_code; // chosen code
    logic        sel_any;  // something chosen

    always_comb begin
        enables[rdip_pkg::DEF_AIS]  = ctrl0_ff[rdip_pkg::LO_EN_BIT];
        enables[rdip_pkg::DEF_LOP]  = ctrl0_ff[rdip_pkg::HI_EN_BIT];
        enables[rdip_pkg::DEF_UNEQ] = ctrl1_ff[rdip_pkg::LO_EN_BIT];
        enables[rdip_pkg::DEF_TIM]  = ctrl1_ff[rdip_pkg::HI_EN_BIT];
        enables[rdip_pkg::DEF_PLM]  = ctrl2_ff[rdip_pkg::LO_EN_BIT];
        enables[rdip_pkg::DEF_LCD]  = ctrl2_ff[rdip_pkg::HI_EN_BIT];
        codes[0 +: 3]  = ctrl0_ff[rdip_pkg::LO_CODE_MSB:rdip_pkg::LO_CODE_LSB];
        codes[3 +: 3]  = ctrl0_ff[rdip_pkg::HI_CODE_MSB:rdip_pkg::HI_CODE_LSB];
        codes[6 +: 3]  = ctrl1_ff[rdip_pkg::LO_CODE_MSB:rdip_pkg::LO_CODE_LSB];
        codes[9 +: 3]  = ctrl1_ff[rdip_pkg::HI_CODE_MSB:rdip_pkg::HI_CODE_LSB];
        codes[12 +: 3] = ctrl2_ff[rdip_pkg::LO_CODE_MSB:rdip_pkg::LO_CODE_LSB];
        codes[15 +: 3] = ctrl2_ff[rdip_pkg::HI_CODE_MSB:rdip_pkg::HI_CODE_LSB];
        declared = {lcd_in, plm_in, tim_in, uneq_in, lop_in, ais_in};
    end

    assign active = declared & enables; // disabled defects never insert

    // priority choice among active defects
    rdip_select u_sel (
        .active_in (active),
        .codes_in  (codes),
        .code_out  (sel_code),
        .any_out   (sel_any)
    );

    ////////////////////////////////////////////////////////////////////////
    // outbound byte: code in bits 7..5, rest passed through
    logic [7:0] nxt_g1; // next outbound byte

    always_comb begin
        nxt_g1 = g1_in;
        nxt_g1[rdip_pkg::G1_CODE_MSB:rdip_pkg::G1_CODE_LSB] = sel_code;
    end

    // registered output stage
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            g1_out      <= 8'h00;
            rdi_act_out <= 1'b0;
        end else begin
            g1_out      <= nxt_g1;
            rdi_act_out <= sel_any;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions
    property p_ais_code; // alarm code wins when enabled
        @(posedge clk_in) disable iff (!rstn_in)
        (ais_in && ctrl0_ff[0]) |=> (g1_out[7:5] == $past(ctrl0_ff[3:1]));
    endproperty
    a_ais_code: assert property (p_ais_code) else $error("alarm code not sent");

    property p_ais_off;
        @(posedge clk_in) disable iff (!rstn_in)
        (!ctrl0_ff[0] && !(lop_in && ctrl0_ff[4]) && !(uneq_in && ctrl1_ff[0]) && !(tim_in && ctrl1_ff[4])
         && !(plm_in && ctrl2_ff[0]) && !(lcd_in && ctrl2_ff[4])) |=> (g1_out[7:5] == 3'h0);
    endproperty
    a_ais_off: assert property (p_ais_off) else $error("code sent without enabled defect");

    property p_tim_code;
        @(posedge clk_in) disable iff (!rstn_in)
        (tim_in && ctrl1_ff[4] && !(ais_in && ctrl0_ff[0]) && !(lop_in && ctrl0_ff[4])
         && !(uneq_in && ctrl1_ff[0])) |=> (g1_out[7:5] == $past(ctrl1_ff[7:5]));
    endproperty
    a_tim_code: assert property (p_tim_code) else $error("trace mismatch code wrong");

    property p_lcd_code;
        @(posedge clk_in) disable iff (!rstn_in)
        (active == 6'h20) |=> (g1_out[7:5] == $past(ctrl2_ff[7:5]));
    endproperty
    a_lcd_code: assert property (p_lcd_code) else $error("delineation loss code wrong");

    property p_lop_code;
        @(posedge clk_in) disable iff (!rstn_in)
        (active[1:0] == 2'h2) |=> (g1_out[7:5] == $past(ctrl0_ff[7:5]));
    endproperty
    a_lop_code: assert property (p_lop_code) else $error("pointer loss code wrong");

    property p_uneq_code;
        @(posedge clk_in) disable iff (!rstn_in)
        (active[2:0] == 3'h4) |=> (g1_out[7:5] == $past(ctrl1_ff[3:1]));
    endproperty
    a_uneq_code: assert property (p_uneq_code) else $error("unequipped code wrong");

    property p_plm_code;
        @(posedge clk_in) disable iff (!rstn_in)
        (active[4:0] == 5'h10) |=> (g1_out[7:5] == $past(ctrl2_ff[3:1]));
    endproperty
    a_plm_code: assert property (p_plm_code) else $error("label mismatch code wrong");

    property p_pass;
        @(posedge clk_in) disable iff (!rstn_in)
        1'b1 |=> (g1_out[4:0] == $past(g1_in[4:0]));
    endproperty
    a_pass: assert property (p_pass) else $error("low overhead bits altered");

    property p_act;
        @(posedge clk_in) disable iff (!rstn_in)
        (active != 6'h00) |=> rdi_act_out;
    endproperty
    a_act: assert property (p_act) else $error("activity flag missing");

    c_ais:  cover property (@(posedge clk_in) disable iff (!rstn_in) ais_in && ctrl0_ff[0]);
    c_multi: cover property (@(posedge clk_in) disable iff (!rstn_in) active[3] && active[5]);
    c_lcd:  cover property (@(posedge clk_in) disable iff (!rstn_in) active == 6'h20);
    c_all:  cover property (@(posedge clk_in) disable iff (!rstn_in) active == 6'h3f);
    c_rd:   cover property (@(posedge clk_in) disable iff (!rstn_in) rd_in && (addr_in == rdip_pkg::ADDR_CTRL_1));

    ////////////////////////////////////////////////////////////////////////
    // register bus checks: writes land, reads answer one edge later
    property p_wr_ctrl0; // byte 0 takes the written value
        @(posedge clk_in) disable iff (!rstn_in)
        (wr_in && (addr_in == rdip_pkg::ADDR_CTRL_0)) |=> (ctrl0_ff == $past(wdata_in));
    endproperty
    a_wr_ctrl0: assert property (p_wr_ctrl0) else $error("byte 0 write lost");

    property p_wr_ctrl1; // byte 1 takes the written value
        @(posedge clk_in) disable iff (!rstn_in)
        (wr_in && (addr_in == rdip_pkg::ADDR_CTRL_1)) |=> (ctrl1_ff == $past(wdata_in));
    endproperty
    a_wr_ctrl1: assert property (p_wr_ctrl1) else $error("byte 1 write lost");

    property p_wr_ctrl2; // byte 2 takes the written value
        @(posedge clk_in) disable iff (!rstn_in)
        (wr_in && (addr_in == rdip_pkg::ADDR_CTRL_2)) |=> (ctrl2_ff == $past(wdata_in));
    endproperty
    a_wr_ctrl2: assert property (p_wr_ctrl2) else $error("byte 2 write lost");

    property p_rd_ctrl0; // byte 0 readback, old value on same-cycle write
        @(posedge clk_in) disable iff (!rstn_in)
        (rd_in && (addr_in == rdip_pkg::ADDR_CTRL_0)) |=> (rdata_out == $past(ctrl0_ff));
    endproperty
    a_rd_ctrl0: assert property (p_rd_ctrl0) else $error("byte 0 readback wrong");

    property p_rd_ctrl1; // byte 1 readback
        @(posedge clk_in) disable iff (!rstn_in)
        (rd_in && (addr_in == rdip_pkg::ADDR_CTRL_1)) |=> (rdata_out == $past(ctrl1_ff));
    endproperty
    a_rd_ctrl1: assert property (p_rd_ctrl1) else $error("byte 1 readback wrong");

    property p_rd_ctrl2; // byte 2 readback
        @(posedge clk_in) disable iff (!rstn_in)
        (rd_in && (addr_in == rdip_pkg::ADDR_CTRL_2)) |=> (rdata_out == $past(ctrl2_ff));
    endproperty
    a_rd_ctrl2: assert property (p_rd_ctrl2) else $error("byte 2 readback wrong");

    property p_rd_unmapped; // holes in the map read as zero
        @(posedge clk_in) disable iff (!rstn_in)
        (rd_in && (addr_in != rdip_pkg::ADDR_CTRL_0) && (addr_in != rdip_pkg::ADDR_CTRL_1)
         && (addr_in != rdip_pkg::ADDR_CTRL_2)) |=> (rdata_out == 8'h00);
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

    property p_rd_hold; // read data stands until the next read
        @(posedge clk_in) disable iff (!rstn_in)
        (!rd_in) |=> $stable(rdata_out);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");

    property p_idle_act; // no enabled defect, no activity flag
        @(posedge clk_in) disable iff (!rstn_in)
        (active == 6'h00) |=> !rdi_act_out;
    endproperty
    a_idle_act: assert property (p_idle_act) else $error("activity flag without defect");
endmodule

// ===== hdl/rdip_pkg.sv
// constants and register layout for the automatic path remote defect insertion block
package rdip_pkg;
    // register addresses on the host interface
    localparam logic [15:0] ADDR_CTRL_2 = 16'h19c9; // delineation loss / label mismatch
    localparam logic [15:0] ADDR_CTRL_1 = 16'h19ca; // trace mismatch / unequipped
    localparam logic [15:0] ADDR_CTRL_0 = 16'h19cb; // pointer loss / alarm signal
    // field positions within each control byte
    localparam int HI_CODE_MSB = 7; // upper code field msb
    localparam int HI_CODE_LSB = 5; // upper code field lsb
    localparam int HI_EN_BIT   = 4; // upper enable bit
    localparam int LO_CODE_MSB = 3; // lower code field msb
    localparam int LO_CODE_LSB = 1; // lower code field lsb
    localparam int LO_EN_BIT   = 0; // lower enable bit
    // position of the code in the outbound overhead byte
    localparam int G1_CODE_MSB = 7; // code msb in outbound byte
    localparam int G1_CODE_LSB = 5; // code lsb in outbound byte
    localparam logic [7:0] CTRL_RESET = 8'h00; // control byte reset value
    localparam logic [2:0] CODE_NONE  = 3'h0;  // code sent with no defect
    localparam int NUM_DEFECTS = 6; // defect sources handled
    // defect index, which is also priority order (0 highest)
    typedef enum logic [2:0] {
        DEF_AIS  = 3'h0, // alarm signal
        DEF_LOP  = 3'h1, // pointer loss
        DEF_UNEQ = 3'h2, // unequipped
        DEF_TIM  = 3'h3, // trace mismatch
        DEF_PLM  = 3'h4, // label mismatch
        DEF_LCD  = 3'h5  // cell delineation loss
    } rdip_defect_t;
endpackage

// ===== hdl/rdip_select.sv
// priority selector choosing one code among enabled active defects
`timescale 1ns/100ps
module rdip_select (
    input  wire logic [5:0]  active_in, // defect declared and enabled, index = priority
    input  wire logic [17:0] codes_in,  // three code bits per defect
    output logic      [2:0]  code_out,  // chosen code
    output logic             any_out    // some defect selected
);
    // lowest index wins; scan from lowest priority upward so the best overwrites
    always_comb begin
        code_out = rdip_pkg::CODE_NONE; // idle sends zeros
        any_out  = 1'b0;
        for (int i = rdip_pkg::NUM_DEFECTS - 1; i >= 0; i--) begin
            if (active_in[i]) begin
                code_out = codes_in[i*3 +: 3];
                any_out  = 1'b1;
            end
        end
    end
endmodule

// ===== tb/rdip_defect_src.sv
// behavioural receive path processor declaring path defect levels
`timescale 1ns/100ps
module rdip_defect_src (
    input  wire logic       clk_in,   // shared clock
    input  wire logic [5:0] cmd_in,   // defects to declare, bit index = priority
    output logic            ais_out,  // alarm signal declared
    output logic            lop_out,  // pointer loss declared
    output logic            uneq_out, // unequipped declared
    output logic            tim_out,  // trace mismatch declared
    output logic            plm_out,  // label mismatch declared
    output logic            lcd_out   // delineation loss declared
);
    ////////////////////////////////////////////////////////////////
    // levels change just after an edge, like a real detector
    // one process owns the outputs: quiet at start, then follow the command
    initial begin
        {lcd_out, plm_out, tim_out, uneq_out, lop_out, ais_out} = 6'h00;
        forever begin
            @(posedge clk_in);
            #1;
            {lcd_out, plm_out, tim_out, uneq_out, lop_out, ais_out} <= cmd_in;
        end
    end
endmodule

// ===== tb/tb_top.sv
// self-checking bench for the automatic path remote defect insertion block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_top;
    logic        clk_in, rstn_in, wr_in, rd_in;      // clock, reset, strobes
    logic [15:0] addr_in;                             // host address
    logic [7:0]  wdata_in, rdata_out, g1_in, g1_out; // host data, overhead bytes
    logic        rdi_act_out;                         // code being sent
    logic        ais, lop, uneq, tim, plm, lcd;       // partner defect lines
    logic [5:0]  defect_cmd;                          // defects to declare
    int          error_cnt, compares, cycles;         // tallies
    logic [2:0]  code_tab [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7}; // code per defect
    logic [7:0]  base_tab [3] = '{8'h42, 8'h86, 8'hea};                 // ctrl bytes, enables clear

    rdip_auto_insert u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .ais_in(ais), .lop_in(lop), .uneq_in(uneq),
        .tim_in(tim), .plm_in(plm), .lcd_in(lcd), .g1_in(g1_in), .g1_out(g1_out), .rdi_act_out(rdi_act_out));
    rdip_defect_src u_src (.clk_in(clk_in), .cmd_in(defect_cmd), .ais_out(ais), .lop_out(lop),
        .uneq_out(uneq), .tim_out(tim), .plm_out(plm), .lcd_out(lcd));

    ////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    ////////////////////////////////////////////////////////////////
    // shared bus and check tasks
    task automatic step();
        @(posedge clk_in);
        #1;
    endtask
    task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
        step();
        addr_in = a; wdata_in = d; wr_in = 1'b1;
        step();
        wr_in = 1'b0;
    endtask
    task automatic reg_rd(input logic [15:0] a, input logic [7:0] exp);
        step();
        addr_in = a; rd_in = 1'b1;
        step();
        rd_in = 1'b0;
        `CHK("rdata_out", exp, rdata_out)
    endtask
    // declare defects, then judge the outbound byte and activity flag
    task automatic expect_out(input logic [5:0] dv, input logic [7:0] g, input logic [2:0] code, input logic act);
        defect_cmd = dv; g1_in = g;
        repeat (3) step();
        `CHK("g1_out", {code, g[4:0]}, g1_out)
        `CHK("rdi_act_out", act, rdi_act_out)
    endtask
    task automatic tally_and_finish();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_regs(); // reset values, readback, unmapped place
        for (int r = 0; r < 3; r++) reg_rd(16'h19cb - 16'(r), 8'h00);
        expect_out(6'h00, 8'hff, 3'h0, 1'b0);
        for (int r = 0; r < 3; r++) reg_wr(16'h19cb - 16'(r), base_tab[r] | 8'h11);
        reg_wr(16'h19cc, 8'hff);
        reg_rd(16'h19cb, 8'h53);
        reg_rd(16'h19ca, 8'h97);
        reg_rd(16'h19c9, 8'hfb);
        reg_rd(16'h19cc, 8'h00);
    endtask
    task automatic t_single_enable(); // all declared, only one enable set
        for (int i = 0; i < 6; i++) begin
            for (int r = 0; r < 3; r++)
                reg_wr(16'h19cb - 16'(r), base_tab[r] | ((r == i / 2) ? ((i % 2) ? 8'h10 : 8'h01) : 8'h00));
            expect_out(6'h3f, 8'he0 + 8'(i * 7), code_tab[i], 1'b1);
        end
    endtask
    task automatic t_disabled(); // codes kept, every enable clear
        for (int r = 0; r < 3; r++) reg_wr(16'h19cb - 16'(r), base_tab[r]);
        expect_out(6'h3f, 8'hff, 3'h0, 1'b0);
    endtask
    task automatic t_priority(); // drop the highest defect one by one
        for (int r = 0; r < 3; r++) reg_wr(16'h19cb - 16'(r), base_tab[r] | 8'h11);
        for (int i = 0; i < 6; i++)
            expect_out(6'h3f << i, 8'h15, code_tab[i], 1'b1);
        expect_out(6'h00, 8'hea, 3'h0, 1'b0);
    endtask
    task automatic t_reset(); // reset in mid-run clears bytes and outputs
        defect_cmd = 6'h3f;
        g1_in = 8'hff;
        rstn_in = 1'b0;
        repeat (2) step();
        `CHK("g1_out", 8'h00, g1_out)
        `CHK("rdi_act_out", 1'b0, rdi_act_out)
        rstn_in = 1'b1;
        for (int r = 0; r < 3; r++) reg_rd(16'h19cb - 16'(r), 8'h00);
        expect_out(6'h3f, 8'hff, 3'h0, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rstn_in = 1'b0; wr_in = 1'b0; rd_in = 1'b0;
        addr_in = 16'h0000; wdata_in = 8'h00; g1_in = 8'h00; defect_cmd = 6'h00;
        repeat (2) step();
        rstn_in = 1'b1;
        t_regs();
        t_single_enable();
        t_disabled();
        t_priority();
        t_reset();
        tally_and_finish();
    end
endmodule
